/* File: hdl/lst_sync_porch_regs.sv */
// sync width and porch registers for two video channels, axi4-lite reached
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module lst_sync_porch_regs
    import lst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [lst_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [lst_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [lst_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [lst_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic aActive,
    output logic aPatternOn,
    output logic [lst_pkg::VS_W-1:0] aVertSyncWidth,
    output logic [lst_pkg::REG_W-1:0] aLineBackGap,
    output logic [lst_pkg::REG_W-1:0] aFrameBackGap,
    output logic [lst_pkg::REG_W-1:0] aLineFrontGap,
    output logic [lst_pkg::REG_W-1:0] aFrameFrontGap,
    output logic bActive,
    output logic bPatternOn,
    output logic [lst_pkg::VS_W-1:0] bVertSyncWidth,
    output logic [lst_pkg::REG_W-1:0] bLineBackGap,
    output logic [lst_pkg::REG_W-1:0] bFrameBackGap,
    output logic [lst_pkg::REG_W-1:0] bLineFrontGap,
    output logic [lst_pkg::REG_W-1:0] bFrameFrontGap
);
    import lst_pkg::*;

    typedef struct packed {
        logic [REG_W-1:0] aVertSyncWidthLower;
        logic [NIB_W-1:0] aVertSyncWidthUpper;
        logic [REG_W-1:0] bVertSyncWidthLower;
        logic [NIB_W-1:0] bVertSyncWidthUpper;
        logic [REG_W-1:0] aLineBack;
        logic [REG_W-1:0] bLineBack;
        logic [REG_W-1:0] aFrameBack;
        logic [REG_W-1:0] bFrameBack;
        logic [REG_W-1:0] aLineFront;
        logic [REG_W-1:0] bLineFront;
        logic [REG_W-1:0] aFrameFront;
        logic [MODE_W-1:0] chanMode;
        logic singleLink;
        logic aPatternGenEnable;
        logic bPatternGenEnable;
    } lst_regs_type;

    lst_regs_type cur_reg;
    lst_regs_type cur_next;
    lst_bsrc_type bSrc;
    logic wrEn;
    logic [IDX_W-1:0] wrIdx;
    logic [REG_W-1:0] wrData;
    logic wrOk;
    logic rdEn;
    logic [IDX_W-1:0] rdIdx;
    logic [REG_W-1:0] rdData;
    logic rdOk;
    logic [VS_W-1:0] aVs;
    logic [VS_W-1:0] bVsOwn;
    logic bOn;
    logic [VS_W-1:0] bVsSel;
    logic [REG_W-1:0] bHbpSel;
    logic [REG_W-1:0] bVbpSel;
    logic [REG_W-1:0] bHfpSel;

    // bus front end; every answer it gives is registered
    lst_axil_port u_port (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrEn(wrEn),
        .wrIdx(wrIdx),
        .wrData(wrData),
        .wrOk(wrOk),
        .rdEn(rdEn),
        .rdIdx(rdIdx),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    // the lower two of the four stored bits extend the low byte to 10 bits
    assign aVs = {cur_reg.aVertSyncWidthUpper[HI_USED-1:0], cur_reg.aVertSyncWidthLower};
    assign bVsOwn = {cur_reg.bVertSyncWidthUpper[HI_USED-1:0], cur_reg.bVertSyncWidthLower};

    // channel B source: own set only in independent mode, else a copy of A
    // in dual link with mode 00/01; single link or mode 11 leaves B idle
    always_comb
    begin
        if (cur_reg.chanMode == MODE_INDEP)
            bSrc = BSRC_OWN;
        else if (!cur_reg.singleLink &&
                 (cur_reg.chanMode == MODE_ZERO || cur_reg.chanMode == MODE_ONE))
            bSrc = BSRC_SHARED;
        else
            bSrc = BSRC_OFF;
    end

    // B picks its set; A's frame front gap serves B in both cases
    always_comb
    begin
        bOn = 1'b1;
        bVsSel = aVs;
        bHbpSel = cur_reg.aLineBack;
        bVbpSel = cur_reg.aFrameBack;
        bHfpSel = cur_reg.aLineFront;
        unique case (bSrc)
            BSRC_OWN:
            begin
                bVsSel = bVsOwn;
                bHbpSel = cur_reg.bLineBack;
                bVbpSel = cur_reg.bFrameBack;
                bHfpSel = cur_reg.bLineFront;
            end
            BSRC_SHARED:
                bOn = 1'b1;
            BSRC_OFF:
                bOn = 1'b0;
        endcase
    end

    // channel A always runs; its test-only porches wait for its enable
    lst_chan_timing u_chan_a (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .chanOn(1'b1),
        .patEn(cur_reg.aPatternGenEnable),
        .vsWidth(aVs),
        .lineBack(cur_reg.aLineBack),
        .frameBack(cur_reg.aFrameBack),
        .lineFront(cur_reg.aLineFront),
        .frameFront(cur_reg.aFrameFront),
        .active(aActive),
        .patternOn(aPatternOn),
        .vertSyncWidth(aVertSyncWidth),
        .lineBackGap(aLineBackGap),
        .frameBackGap(aFrameBackGap),
        .lineFrontGap(aLineFrontGap),
        .frameFrontGap(aFrameFrontGap)
    );

    // a shared B follows A's enable, an independent B its own
    lst_chan_timing u_chan_b (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .chanOn(bOn),
        .patEn(bSrc == BSRC_OWN ? cur_reg.bPatternGenEnable
                                : cur_reg.aPatternGenEnable),
        .vsWidth(bVsSel),
        .lineBack(bHbpSel),
        .frameBack(bVbpSel),
        .lineFront(bHfpSel),
        .frameFront(cur_reg.aFrameFront),
        .active(bActive),
        .patternOn(bPatternOn),
        .vertSyncWidth(bVertSyncWidth),
        .lineBackGap(bLineBackGap),
        .frameBackGap(bFrameBackGap),
        .lineFrontGap(bLineFrontGap),
        .frameFrontGap(bFrameFrontGap)
    );

    // mapped indices; the status word accepts writes and drops them
    assign wrOk = (wrIdx >= IDX_A_VS_LO && wrIdx <= IDX_A_VFP) ||
                  wrIdx == IDX_CTRL || wrIdx == IDX_STAT;

    // register writes; byte lane 0 carries every field
    always_comb
    begin
        cur_next = cur_reg;
        if (wrEn)
        begin
            case (wrIdx)
                IDX_A_VS_LO: cur_next.aVertSyncWidthLower = wrData;
                IDX_A_VS_HI: cur_next.aVertSyncWidthUpper = wrData[NIB_W-1:0];
                IDX_B_VS_LO: cur_next.bVertSyncWidthLower = wrData;
                IDX_B_VS_HI: cur_next.bVertSyncWidthUpper = wrData[NIB_W-1:0];
                IDX_A_HBP: cur_next.aLineBack = wrData;
                IDX_B_HBP: cur_next.bLineBack = wrData;
                IDX_A_VBP: cur_next.aFrameBack = wrData;
                IDX_B_VBP: cur_next.bFrameBack = wrData;
                IDX_A_HFP: cur_next.aLineFront = wrData;
                IDX_B_HFP: cur_next.bLineFront = wrData;
                IDX_A_VFP: cur_next.aFrameFront = wrData;
                IDX_CTRL:
                begin
                    cur_next.chanMode = wrData[CTRL_MODE_LSB+:MODE_W];
                    cur_next.singleLink = wrData[CTRL_SINGLE_BIT];
                    cur_next.aPatternGenEnable = wrData[CTRL_PAT_A_BIT];
                    cur_next.bPatternGenEnable = wrData[CTRL_PAT_B_BIT];
                end
                default: cur_next = cur_reg;
            endcase
        end
    end

    // read mux; reserved bits return zero
    always_comb
    begin
        rdData = RST_BYTE;
        rdOk = 1'b1;
        case (rdIdx)
            IDX_A_VS_LO: rdData = cur_reg.aVertSyncWidthLower;
            IDX_A_VS_HI: rdData[NIB_W-1:0] = cur_reg.aVertSyncWidthUpper;
            IDX_B_VS_LO: rdData = cur_reg.bVertSyncWidthLower;
            IDX_B_VS_HI: rdData[NIB_W-1:0] = cur_reg.bVertSyncWidthUpper;
            IDX_A_HBP: rdData = cur_reg.aLineBack;
            IDX_B_HBP: rdData = cur_reg.bLineBack;
            IDX_A_VBP: rdData = cur_reg.aFrameBack;
            IDX_B_VBP: rdData = cur_reg.bFrameBack;
            IDX_A_HFP: rdData = cur_reg.aLineFront;
            IDX_B_HFP: rdData = cur_reg.bLineFront;
            IDX_A_VFP: rdData = cur_reg.aFrameFront;
            IDX_CTRL:
            begin
                rdData[CTRL_MODE_LSB+:MODE_W] = cur_reg.chanMode;
                rdData[CTRL_SINGLE_BIT] = cur_reg.singleLink;
                rdData[CTRL_PAT_A_BIT] = cur_reg.aPatternGenEnable;
                rdData[CTRL_PAT_B_BIT] = cur_reg.bPatternGenEnable;
            end
            IDX_STAT:
            begin
                rdData[STAT_B_OWN_BIT] = bActive & (bSrc == BSRC_OWN);
                rdData[STAT_B_SHARED_BIT] = bActive & (bSrc == BSRC_SHARED);
                rdData[STAT_PAT_A_BIT] = aPatternOn;
                rdData[STAT_PAT_B_BIT] = bPatternOn;
            end
            default: rdOk = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cur_reg <= '0;
        else
            cur_reg <= cur_next;
    end

    // ---- checks ----
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence seqWrAHi;
        wrEn && wrIdx == IDX_A_VS_HI;
    endsequence

    sequence seqIndepHeld;
        cur_reg.chanMode == MODE_INDEP [*2];
    endsequence

    // three samples: the channel flops lag reset release by one edge
    sequence seqSharedHeld;
        (!cur_reg.singleLink && cur_reg.chanMode == MODE_ZERO) [*3];
    endsequence

    // a high write reaches the output width two edges later
    AST_A_VS_UPPER: assert property (seqWrAHi ##1 (!wrEn [*2]) |->
        aVertSyncWidth[VS_W-1:REG_W] == $past(wrData[HI_USED-1:0], 2))
        else $error("channel A sync width upper bits not applied");

    AST_SHARED_B: assert property (seqSharedHeld |->
        bActive && bVertSyncWidth == aVertSyncWidth && bLineBackGap == aLineBackGap)
        else $error("shared channel B differs from channel A");

    AST_B_VS_OWN: assert property (seqIndepHeld |->
        bVertSyncWidth == $past(bVsOwn))
        else $error("channel B own sync width not applied");

    AST_A_HBP: assert property ($stable(cur_reg.aLineBack) |->
        aLineBackGap == cur_reg.aLineBack)
        else $error("channel A line back gap not applied");

    AST_B_HBP_OWN: assert property (seqIndepHeld ##0 $stable(cur_reg.bLineBack) |->
        bLineBackGap == cur_reg.bLineBack)
        else $error("channel B own line back gap not applied");

    AST_A_VBP_GATE: assert property (!cur_reg.aPatternGenEnable |=>
        aFrameBackGap == RST_BYTE)
        else $error("channel A frame back gap leaked without pattern");

    AST_B_VBP_OWN: assert property ((seqIndepHeld ##0 $past(cur_reg.bPatternGenEnable)) |->
        bFrameBackGap == $past(cur_reg.bFrameBack))
        else $error("channel B frame back gap not applied");

    AST_A_HFP: assert property (cur_reg.aPatternGenEnable |=>
        aLineFrontGap == $past(cur_reg.aLineFront))
        else $error("channel A line front gap not applied");

    AST_B_HFP_OFF: assert property (bSrc == BSRC_OFF |=>
        !bActive && bLineFrontGap == RST_BYTE && !bPatternOn)
        else $error("idle channel B shows timing");

    AST_PATTERN_ON: assert property ($rose(cur_reg.aPatternGenEnable) |->
        !aPatternOn ##1 aPatternOn)
        else $error("channel A pattern did not start one edge after enable");

    AST_A_VFP: assert property (!cur_reg.aPatternGenEnable |=>
        aFrameFrontGap == RST_BYTE)
        else $error("channel A frame front gap leaked without pattern");

    AST_HI_NIBBLE: assert property (rdEn && (rdIdx == IDX_A_VS_HI ||
        rdIdx == IDX_B_VS_HI) |=> s_axi_rdata[REG_W-1:NIB_W] == '0)
        else $error("reserved nibble of sync width high read non-zero");

    AST_RD_LAT: assert property (rdEn |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one edge after address");
endmodule

/* File: hdl/lst_pkg.sv */
// constants and types shared by the sync and porch timing register block
package lst_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int VS_W = 10;
    localparam int IDX_W = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = IDX_LSB + IDX_W - 1;
    localparam int NIB_W = 4;
    localparam int HI_USED = 2;
    localparam int MODE_W = 2;
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_A_VS_LO = 8'h30;
    localparam logic [IDX_W-1:0] IDX_A_VS_HI = 8'h31;
    localparam logic [IDX_W-1:0] IDX_B_VS_LO = 8'h32;
    localparam logic [IDX_W-1:0] IDX_B_VS_HI = 8'h33;
    localparam logic [IDX_W-1:0] IDX_A_HBP = 8'h34;
    localparam logic [IDX_W-1:0] IDX_B_HBP = 8'h35;
    localparam logic [IDX_W-1:0] IDX_A_VBP = 8'h36;
    localparam logic [IDX_W-1:0] IDX_B_VBP = 8'h37;
    localparam logic [IDX_W-1:0] IDX_A_HFP = 8'h38;
    localparam logic [IDX_W-1:0] IDX_B_HFP = 8'h39;
    localparam logic [IDX_W-1:0] IDX_A_VFP = 8'h3a;
    localparam logic [IDX_W-1:0] IDX_CTRL = 8'h40;
    localparam logic [IDX_W-1:0] IDX_STAT = 8'h41;
    // control and status field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SINGLE_BIT = 2;
    localparam int CTRL_PAT_A_BIT = 3;
    localparam int CTRL_PAT_B_BIT = 4;
    localparam int STAT_B_OWN_BIT = 0;
    localparam int STAT_B_SHARED_BIT = 1;
    localparam int STAT_PAT_A_BIT = 2;
    localparam int STAT_PAT_B_BIT = 3;
    localparam logic [MODE_W-1:0] MODE_ZERO = 2'h0;
    localparam logic [MODE_W-1:0] MODE_ONE = 2'h1;
    localparam logic [MODE_W-1:0] MODE_INDEP = 2'h2;
    localparam logic [REG_W-1:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // where channel B takes its timing from
    typedef enum logic [2:0] {
        BSRC_OFF = 3'b001,
        BSRC_SHARED = 3'b010,
        BSRC_OWN = 3'b100
    } lst_bsrc_type;
endpackage

/* File: hdl/lst_chan_timing.sv */
// one channel's applied timing values, with test-pattern-only fields gated
`timescale 1ns/1ps
module lst_chan_timing
    import lst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic chanOn,
    input wire logic patEn,
    input wire logic [VS_W-1:0] vsWidth,
    input wire logic [REG_W-1:0] lineBack,
    input wire logic [REG_W-1:0] frameBack,
    input wire logic [REG_W-1:0] lineFront,
    input wire logic [REG_W-1:0] frameFront,
    output logic active,
    output logic patternOn,
    output logic [VS_W-1:0] vertSyncWidth,
    output logic [REG_W-1:0] lineBackGap,
    output logic [REG_W-1:0] frameBackGap,
    output logic [REG_W-1:0] lineFrontGap,
    output logic [REG_W-1:0] frameFrontGap
);
    typedef struct packed {
        logic act;
        logic pat;
        logic [VS_W-1:0] vs;
        logic [REG_W-1:0] hbp;
        logic [REG_W-1:0] vbp;
        logic [REG_W-1:0] hfp;
        logic [REG_W-1:0] vfp;
    } lst_chan_type;
    lst_chan_type cur_reg;
    lst_chan_type cur_next;

    // porches that only the pattern generator uses read zero otherwise,
    // so the video path can never pick up a stale test value
    always_comb
    begin
        cur_next = '0;
        cur_next.act = chanOn;
        cur_next.pat = chanOn & patEn;
        if (chanOn)
        begin
            cur_next.vs = vsWidth;
            cur_next.hbp = lineBack;
        end
        if (chanOn && patEn)
        begin
            cur_next.vbp = frameBack;
            cur_next.hfp = lineFront;
            cur_next.vfp = frameFront;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cur_reg <= '0;
        else
            cur_reg <= cur_next;
    end

    assign active = cur_reg.act;
    assign patternOn = cur_reg.pat;
    assign vertSyncWidth = cur_reg.vs;
    assign lineBackGap = cur_reg.hbp;
    assign frameBackGap = cur_reg.vbp;
    assign lineFrontGap = cur_reg.hfp;
    assign frameFrontGap = cur_reg.vfp;
endmodule

/* File: hdl/lst_axil_port.sv */
// axi4-lite slave front end: handshakes, index decode, registered answers
`timescale 1ns/1ps
module lst_axil_port
    import lst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wrEn,
    output logic [IDX_W-1:0] wrIdx,
    output logic [REG_W-1:0] wrData,
    input wire logic wrOk,
    output logic rdEn,
    output logic [IDX_W-1:0] rdIdx,
    input wire logic [REG_W-1:0] rdData,
    input wire logic rdOk
);
    typedef struct packed {
        logic awRdy;
        logic wRdy;
        logic awHeld;
        logic wHeld;
        logic [ADDR_W-1:0] awAddr;
        logic [REG_W-1:0] wData;
        logic wLane0;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [1:0] rResp;
        logic [REG_W-1:0] rData;
    } lst_port_type;
    lst_port_type cur_reg;
    lst_port_type cur_next;
    logic [ADDR_W-1:0] wAddr;

    // misaligned or out-of-window addresses decode to no register
    function automatic logic addrBad(input logic [ADDR_W-1:0] a);
        addrBad = (a[IDX_LSB-1:0] != '0) || (a[ADDR_W-1:IDX_MSB+1] != '0);
    endfunction

    // a write fires once both halves are held; bresp waits on bready
    always_comb
    begin
        cur_next = cur_reg;
        wrEn = 1'b0;
        rdEn = 1'b0;
        if (s_axi_awvalid && cur_reg.awRdy)
        begin
            cur_next.awHeld = 1'b1;
            cur_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && cur_reg.wRdy)
        begin
            cur_next.wHeld = 1'b1;
            cur_next.wData = s_axi_wdata[REG_W-1:0];
            cur_next.wLane0 = s_axi_wstrb[0];
        end
        wAddr = cur_next.awAddr;
        if (cur_next.awHeld && cur_next.wHeld && !cur_reg.bValid)
        begin
            wrEn = cur_next.wLane0 & ~addrBad(wAddr);
            cur_next.awHeld = 1'b0;
            cur_next.wHeld = 1'b0;
            cur_next.bValid = 1'b1;
            cur_next.bResp = (!addrBad(wAddr) && wrOk) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (cur_reg.bValid && s_axi_bready)
            cur_next.bValid = 1'b0;
        cur_next.awRdy = ~cur_next.awHeld & ~cur_next.bValid;
        cur_next.wRdy = ~cur_next.wHeld & ~cur_next.bValid;
        // one read at a time; data is sampled at the address edge
        if (s_axi_arvalid && cur_reg.arRdy)
        begin
            rdEn = 1'b1;
            cur_next.arRdy = 1'b0;
            cur_next.rValid = 1'b1;
            cur_next.rData = addrBad(s_axi_araddr) ? RST_BYTE : rdData;
            cur_next.rResp = (!addrBad(s_axi_araddr) && rdOk) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (cur_reg.rValid && s_axi_rready)
        begin
            cur_next.rValid = 1'b0;
            cur_next.arRdy = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur_reg <= '0;
            cur_reg.awRdy <= 1'b1;
            cur_reg.wRdy <= 1'b1;
            cur_reg.arRdy <= 1'b1;
        end
        else
            cur_reg <= cur_next;
    end

    assign wrIdx = wAddr[IDX_MSB:IDX_LSB];
    assign wrData = cur_next.wData;
    assign rdIdx = s_axi_araddr[IDX_MSB:IDX_LSB];
    assign s_axi_awready = cur_reg.awRdy;
    assign s_axi_wready = cur_reg.wRdy;
    assign s_axi_bvalid = cur_reg.bValid;
    assign s_axi_bresp = cur_reg.bResp;
    assign s_axi_arready = cur_reg.arRdy;
    assign s_axi_rvalid = cur_reg.rValid;
    assign s_axi_rresp = cur_reg.rResp;
    assign s_axi_rdata = {{(DATA_W-REG_W){1'b0}}, cur_reg.rData};
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the sync and porch timing register block
`timescale 1ns/1ps
module testbench;
import lst_pkg::*;
logic sys_clk = 1'b0, arst_n = 1'b0;
logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
logic [3:0] s_axi_wstrb = 4'h1;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
logic aActive, aPatternOn, bActive, bPatternOn;
logic [VS_W-1:0] aVertSyncWidth, bVertSyncWidth;
logic [REG_W-1:0] aLineBackGap, aFrameBackGap, aLineFrontGap, aFrameFrontGap;
logic [REG_W-1:0] bLineBackGap, bFrameBackGap, bLineFrontGap, bFrameFrontGap;
logic [31:0] rd;
int n_fail = 0, checked = 0, cyc = 0;
lst_sync_porch_regs lst_sync_porch_regs_i (.*);
// free-running 250 MHz clock and a hang guard
always #2 sys_clk = ~sys_clk;
always @(posedge sys_clk)
begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
        n_fail++;
        close_out();
    end
end
task automatic close_out();
    if (n_fail == 0 && checked > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        n_fail++;
    end
endtask
function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] i);
    return {2'h0, i, 2'h0};
endfunction
// one write; returns after the outputs have had their extra edge to follow
task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= ba(i);
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
        @(posedge sys_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
    #1;
endtask
task automatic rdr(input logic [IDX_W-1:0] i);
    @(posedge sys_clk);
    s_axi_araddr <= ba(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
        @(posedge sys_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask
// dual link sharing A in modes 00 and 01, then single link idles B
task automatic t_shared();
    for (int m = 0; m < 2; m++)
    begin
        wr(IDX_CTRL, 8'(m));
        wr(IDX_A_VS_LO, 8'hab);
        wr(IDX_A_VS_HI, 8'hf3);
        wr(IDX_A_HBP, 8'h5c);
        chk("wrResp", 32'(RESP_OKAY), rsp);
        chk("aVertSyncWidth", 32'h3ab, aVertSyncWidth);
        chk("bVertSyncWidth", 32'h3ab, bVertSyncWidth);
        chk("bLineBackGap", 32'h5c, bLineBackGap);
        rdr(IDX_A_VS_HI);
        chk("vsHighRead", 32'h03, rd);
        chk("rdResp", 32'(RESP_OKAY), rsp);
    end
    wr(IDX_CTRL, 8'h04);
    chk("bActive", 32'h0, bActive);
    chk("aLineBackGap", 32'h5c, aLineBackGap);
endtask
// independent channels: B takes its own set, patterns gate porch outputs
task automatic t_indep();
    wr(IDX_CTRL, 8'h02);
    wr(IDX_B_VS_LO, 8'h12);
    wr(IDX_B_VS_HI, 8'hf2);
    wr(IDX_B_HBP, 8'h77);
    wr(IDX_A_VBP, 8'h21);
    wr(IDX_A_HFP, 8'h22);
    wr(IDX_A_VFP, 8'h23);
    wr(IDX_B_VBP, 8'h31);
    wr(IDX_B_HFP, 8'h32);
    chk("bVertSyncWidth", 32'h212, bVertSyncWidth);
    chk("bLineBackGap", 32'h77, bLineBackGap);
    chk("aFrameBackGapOff", 32'h0, aFrameBackGap);
    chk("bLineFrontGapOff", 32'h0, bLineFrontGap);
    wr(IDX_CTRL, 8'h1a);
    chk("aFrameBackGap", 32'h21, aFrameBackGap);
    chk("aLineFrontGap", 32'h22, aLineFrontGap);
    chk("aFrameFrontGap", 32'h23, aFrameFrontGap);
    chk("bFrameBackGap", 32'h31, bFrameBackGap);
    chk("bLineFrontGap", 32'h32, bLineFrontGap);
    chk("aPatternOn", 32'h1, aPatternOn);
    chk("bPatternOn", 32'h1, bPatternOn);
    chk("bFrameFrontGap", 32'h23, bFrameFrontGap);
    rdr(IDX_STAT);
    chk("statusRead", 32'h0d, rd);
    // single link bit does not matter in independent mode; mode 11 idles B
    wr(IDX_CTRL, 8'h06);
    chk("bSingleOwnWidth", 32'h212, bVertSyncWidth);
    wr(IDX_CTRL, 8'h03);
    chk("bActiveMode3", 32'h0, bActive);
    chk("bLineBackGapMode3", 32'h0, bLineBackGap);
endtask
// an unmapped index is refused on both paths
task automatic t_unmapped();
    wr(8'h50, 8'h55);
    chk("unmappedWrResp", 32'(RESP_SLVERR), rsp);
    rdr(8'h50);
    chk("unmappedRdResp", 32'(RESP_SLVERR), rsp);
    // lane 0 clear: the write is answered but must not land
    @(posedge sys_clk);
    s_axi_wstrb <= 4'h0;
    wr(IDX_B_HBP, 8'h99);
    chk("maskedWrResp", 32'(RESP_OKAY), rsp);
    rdr(IDX_B_HBP);
    s_axi_wstrb <= 4'h1;
    chk("maskedWrKept", 32'h77, rd);
endtask
initial
begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("aActive", 32'h1, aActive);
    t_shared();
    t_indep();
    t_unmapped();
    close_out();
end
endmodule
